// ==== rsl_consts.vh ====
// Purpose: shared constants of the reset state loader
// Assumes: included by bare name from the regbank, loader, checker and bench files
// Notes: byte addresses of the apb register map, reset images, field positions
`ifndef RSL_CONSTS_VH
`define RSL_CONSTS_VH

// ----------------------------------------
// bus and widths
// ----------------------------------------
`define RSL_ADDR_W 8
`define RSL_WORD_W 32
`define RSL_SYNC_LAT 4'h3

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define RSL_A_FP_CTRL 8'h00
`define RSL_A_FP_STAT 8'h04
`define RSL_A_FP_TAG 8'h08
`define RSL_A_FP_SEL 8'h0c
`define RSL_A_FP_DPTR 8'h10
`define RSL_A_FP_IPTR 8'h14
`define RSL_A_VEC_CSR 8'h18
`define RSL_A_FLAGS 8'h1c
`define RSL_A_CR0 8'h20
`define RSL_A_ACC 8'h24
`define RSL_A_FEAT 8'h28
`define RSL_A_TSC_LO 8'h2c
`define RSL_A_TSC_HI 8'h30
`define RSL_A_PERF 8'h34
`define RSL_A_EVSEL 8'h38
`define RSL_A_MSR 8'h3c
`define RSL_A_MCA 8'h40
`define RSL_A_BSEL 8'h44
`define RSL_A_BDATA 8'h48
`define RSL_A_STATE 8'h4c

// ----------------------------------------
// reset and initialize images
// ----------------------------------------
`define RSL_FPCW_RST 16'h0040
`define RSL_FPCW_INI 16'h037f
`define RSL_FPTW_RST 16'h5555
`define RSL_FPTW_INI 16'hffff
`define RSL_ZERO16 16'h0000
`define RSL_ZERO32 32'h00000000
`define RSL_ZERO64 64'h0000000000000000
`define RSL_VCSR_RST 32'h00001f80
`define RSL_FLAGS_RST 32'h00000002
`define RSL_FLAGS_KEEP 32'hffc00000
`define RSL_CR0_PWRUP 32'h60000010
`define RSL_CR0_KEEP 32'h60000000
`define RSL_CR0_SET 32'h00000010
`define RSL_BUILT_IN_SELF_TEST_FAIL 32'h00000001
`define RSL_BUILT_IN_SELF_TEST_CYC_DEF 16'h0040
`define RSL_FEAT_RST 3'h1

// ----------------------------------------
// field positions
// ----------------------------------------
`define RSL_FEAT_LOCAL_INTERRUPT_CONTROLLER 0
`define RSL_FEAT_MFIX 1
`define RSL_FEAT_MVAR 2
`define RSL_EVSEL_EN 0
`define RSL_BSEL_BANK 1:0
`define RSL_BSEL_ENT 6:4
`define RSL_BSEL_WORD 9:8
`define RSL_BANK_STK 2'h0
`define RSL_BANK_PKD 2'h1
`define RSL_BANK_VEC 2'h2

`endif

// ==== rsl_sync.v ====
// Purpose: two-flop synchroniser for pins from outside the pclk domain
// Assumes: each bit is an independent level
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module rsl_sync #(
  parameter W = 3
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  // ----------------------------------------
  // per-bit stages
  // ----------------------------------------
  genvar b;
  generate
    for (b = 0; b < W; b = b + 1) begin : g_bit
      reg s1_r;
      reg s2_r;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
        end else begin
          s1_r <= d[b];
          s2_r <= s1_r;
        end
      end
      assign q[b] = s2_r;
    end
  endgenerate
endmodule

// ==== rsl_regbank.v ====
// Purpose: bank of wide data registers with word access and bulk clear
// Assumes: clr and we come from the pclk domain
// Notes: clear has priority over a word write in the same cycle
`timescale 1ns/1ps
`include "rsl_consts.vh"
module rsl_regbank #(
  parameter W = 80,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire rst_n,
  input wire clr,
  input wire we,
  input wire [AW-1:0] idx,
  input wire [1:0] wsel,
  input wire [`RSL_WORD_W-1:0] wdata,
  output wire [`RSL_WORD_W-1:0] rdata,
  output wire nonzero
);
  reg [W-1:0] mem [0:DEPTH-1];
  wire [6:0] sh;
  wire [W+`RSL_WORD_W-1:0] rd_pad;
  wire [W+`RSL_WORD_W-1:0] mask_w;
  wire [W+`RSL_WORD_W-1:0] data_w;
  wire [DEPTH-1:0] nz;

  // ----------------------------------------
  // word select
  // ----------------------------------------
  assign sh = {wsel, 5'h00};
  assign rd_pad = {{`RSL_WORD_W{1'b0}}, mem[idx]} >> sh;
  assign rdata = rd_pad[`RSL_WORD_W-1:0];
  assign mask_w = {{W{1'b0}}, {`RSL_WORD_W{1'b1}}} << sh;
  assign data_w = {{W{1'b0}}, wdata} << sh;
  assign nonzero = |nz;

  // ----------------------------------------
  // entries
  // ----------------------------------------
  genvar e;
  generate
    for (e = 0; e < DEPTH; e = e + 1) begin : g_ent
      localparam [AW-1:0] EI = e;
      assign nz[e] = |mem[e];
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          mem[e] <= {W{1'b0}};
        end else if (clr) begin
          mem[e] <= {W{1'b0}};
        end else if (we && idx == EI) begin
          mem[e] <= (mem[e] & ~mask_w[W-1:0]) | (data_w[W-1:0] & mask_w[W-1:0]);
        end
      end
    end
  endgenerate
endmodule

// ==== rsl_loader.v ====
// Purpose: architectural state loader for hard reset, soft init, fp initialize
// Assumes: apb slave, zero wait states; pins synchronised here
// Notes: event priority is hard reset, then soft init, then fp initialize
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "rsl_consts.vh"
module rsl_loader #(
  parameter [15:0] BUILT_IN_SELF_TEST_CYCLES = `RSL_BUILT_IN_SELF_TEST_CYC_DEF
) (
  input wire pclk,
  input wire presetn,
  input wire [`RSL_ADDR_W-1:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire hw_reset_pin,
  input wire soft_init_pin,
  input wire built_in_self_test_req_pin,
  input wire fp_initialize_instruction,
  input wire perf_event,
  output wire [31:0] control_register_zero,
  output wire local_interrupt_controller_enable,
  output wire mtrr_fixed_enable,
  output wire mtrr_var_enable,
  output reg inv_translation_buffers,
  output reg inv_branch_target_buffer,
  output wire built_in_self_test_busy
);
  localparam [2:0] ST_ARM = 3'b001;
  localparam [2:0] ST_BUILT_IN_SELF_TEST = 3'b010;
  localparam [2:0] ST_IDLE = 3'b100;

  // ----------------------------------------
  // pin synchronisers and events
  // ----------------------------------------
  wire [2:0] pins_s;
  wire hw_s;
  wire si_s;
  wire built_in_self_test_s;
  reg si_d_r;
  wire hw_act;
  wire si_evt;
  wire fi_evt;

  rsl_sync #(
    .W(3)
  ) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({built_in_self_test_req_pin, soft_init_pin, hw_reset_pin}),
    .q(pins_s)
  );

  assign hw_s = pins_s[0];
  assign si_s = pins_s[1];
  assign built_in_self_test_s = pins_s[2];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      si_d_r <= 1'b0;
    end else begin
      si_d_r <= si_s;
    end
  end

  // hard reset is a level: state is held at its image while asserted
  assign hw_act = hw_s;
  assign si_evt = si_s & ~si_d_r & ~hw_act;
  assign fi_evt = fp_initialize_instruction & ~hw_act & ~si_evt;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  reg mapped;
  wire wr;
  wire rd_setup;

  always @* begin
    case (paddr)
      `RSL_A_FP_CTRL, `RSL_A_FP_STAT, `RSL_A_FP_TAG, `RSL_A_FP_SEL,
      `RSL_A_FP_DPTR, `RSL_A_FP_IPTR, `RSL_A_VEC_CSR, `RSL_A_FLAGS,
      `RSL_A_CR0, `RSL_A_ACC, `RSL_A_FEAT, `RSL_A_TSC_LO, `RSL_A_TSC_HI,
      `RSL_A_PERF, `RSL_A_EVSEL, `RSL_A_MSR, `RSL_A_MCA, `RSL_A_BSEL,
      `RSL_A_BDATA, `RSL_A_STATE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // no wait states; unmapped accesses error out and change nothing
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign wr = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;

  // ----------------------------------------
  // fp control, status, tag, selectors, pointers
  // ----------------------------------------
  reg [15:0] fp_ctrl_r;
  reg [15:0] fp_stat_r;
  reg [15:0] fp_tag_r;
  reg [31:0] fp_sel_r;
  reg [31:0] fp_dptr_r;
  reg [31:0] fp_iptr_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fp_ctrl_r <= `RSL_FPCW_RST;
      fp_stat_r <= `RSL_ZERO16;
      fp_tag_r <= `RSL_FPTW_RST;
      fp_sel_r <= `RSL_ZERO32;
      fp_dptr_r <= `RSL_ZERO32;
      fp_iptr_r <= `RSL_ZERO32;
    end else if (hw_act) begin
      fp_ctrl_r <= `RSL_FPCW_RST;
      fp_stat_r <= `RSL_ZERO16;
      fp_tag_r <= `RSL_FPTW_RST;
      fp_sel_r <= `RSL_ZERO32;
      fp_dptr_r <= `RSL_ZERO32;
      fp_iptr_r <= `RSL_ZERO32;
    end else if (fi_evt) begin
      fp_ctrl_r <= `RSL_FPCW_INI;
      fp_stat_r <= `RSL_ZERO16;
      fp_tag_r <= `RSL_FPTW_INI;
      fp_sel_r <= `RSL_ZERO32;
      fp_dptr_r <= `RSL_ZERO32;
      fp_iptr_r <= `RSL_ZERO32;
    end else if (wr && !si_evt) begin
      // soft init leaves every fp word alone
      if (paddr == `RSL_A_FP_CTRL) fp_ctrl_r <= pwdata[15:0];
      if (paddr == `RSL_A_FP_STAT) fp_stat_r <= pwdata[15:0];
      if (paddr == `RSL_A_FP_TAG) fp_tag_r <= pwdata[15:0];
      if (paddr == `RSL_A_FP_SEL) fp_sel_r <= pwdata;
      if (paddr == `RSL_A_FP_DPTR) fp_dptr_r <= pwdata;
      if (paddr == `RSL_A_FP_IPTR) fp_iptr_r <= pwdata;
    end
  end

  // ----------------------------------------
  // vector csr, flags, control register zero, feature enables
  // ----------------------------------------
  reg [31:0] vcsr_r;
  reg [31:0] flags_r;
  reg [31:0] cr0_r;
  reg [2:0] feat_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vcsr_r <= `RSL_VCSR_RST;
      flags_r <= `RSL_FLAGS_RST;
      cr0_r <= `RSL_CR0_PWRUP;
      feat_r <= `RSL_FEAT_RST;
    end else if (hw_act) begin
      vcsr_r <= `RSL_VCSR_RST;
      // upper flags bits are left free, which saves a reset path
      flags_r <= (flags_r & `RSL_FLAGS_KEEP) | `RSL_FLAGS_RST;
      cr0_r <= (cr0_r & `RSL_CR0_KEEP) | `RSL_CR0_SET;
      feat_r[`RSL_FEAT_LOCAL_INTERRUPT_CONTROLLER] <= 1'b1;
      feat_r[`RSL_FEAT_MFIX] <= 1'b0;
      feat_r[`RSL_FEAT_MVAR] <= 1'b0;
    end else if (si_evt) begin
      // soft init drops back to real mode; vector csr and enables kept
      flags_r <= (flags_r & `RSL_FLAGS_KEEP) | `RSL_FLAGS_RST;
      cr0_r <= (cr0_r & `RSL_CR0_KEEP) | `RSL_CR0_SET;
    end else if (wr) begin
      if (paddr == `RSL_A_VEC_CSR) vcsr_r <= pwdata;
      if (paddr == `RSL_A_FLAGS) flags_r <= pwdata;
      if (paddr == `RSL_A_CR0) cr0_r <= pwdata;
      if (paddr == `RSL_A_FEAT) feat_r <= pwdata[2:0];
    end
  end

  assign control_register_zero = cr0_r;
  assign local_interrupt_controller_enable = feat_r[`RSL_FEAT_LOCAL_INTERRUPT_CONTROLLER];
  assign mtrr_fixed_enable = feat_r[`RSL_FEAT_MFIX];
  assign mtrr_var_enable = feat_r[`RSL_FEAT_MVAR];

  // ----------------------------------------
  // timestamp, performance counter, event select
  // ----------------------------------------
  reg [63:0] tsc_r;
  reg [31:0] perf_r;
  reg [31:0] evsel_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tsc_r <= `RSL_ZERO64;
      perf_r <= `RSL_ZERO32;
      evsel_r <= `RSL_ZERO32;
    end else if (hw_act) begin
      tsc_r <= `RSL_ZERO64;
      perf_r <= `RSL_ZERO32;
      evsel_r <= `RSL_ZERO32;
    end else begin
      // soft init falls through here, so counting carries on
      tsc_r <= tsc_r + 64'h1;
      if (wr && paddr == `RSL_A_PERF) begin
        perf_r <= pwdata;
      end else if (evsel_r[`RSL_EVSEL_EN] && perf_event) begin
        perf_r <= perf_r + 32'h1;
      end
      if (wr && paddr == `RSL_A_EVSEL) evsel_r <= pwdata;
    end
  end

  // ----------------------------------------
  // registers with no defined reset value
  // ----------------------------------------
  // no reset on purpose: content is unknown after power-up, kept by all events
  reg [31:0] msr_r;
  reg [31:0] mca_r;

  always @(posedge pclk) begin
    if (wr && paddr == `RSL_A_MSR) msr_r <= pwdata;
    if (wr && paddr == `RSL_A_MCA) mca_r <= pwdata;
  end

  // ----------------------------------------
  // stack, packed and vector data banks
  // ----------------------------------------
  reg [9:0] bsel_r;
  wire bwr;
  wire [31:0] stk_rd;
  wire [31:0] pkd_rd;
  wire [31:0] vec_rd;
  wire stk_nz;
  wire pkd_nz;
  wire vec_nz;
  reg [31:0] bank_rd;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bsel_r <= 10'h000;
    end else if (wr && paddr == `RSL_A_BSEL) begin
      bsel_r <= pwdata[9:0];
    end
  end

  // events take the cycle; a bank write that meets one is dropped
  assign bwr = wr && paddr == `RSL_A_BDATA && !hw_act && !si_evt && !fi_evt;

  rsl_regbank #(
    .W(80),
    .DEPTH(8),
    .AW(3)
  ) u_stk (
    .clk(pclk),
    .rst_n(presetn),
    .clr(hw_act),
    .we(bwr && bsel_r[`RSL_BSEL_BANK] == `RSL_BANK_STK),
    .idx(bsel_r[`RSL_BSEL_ENT]),
    .wsel(bsel_r[`RSL_BSEL_WORD]),
    .wdata(pwdata),
    .rdata(stk_rd),
    .nonzero(stk_nz)
  );

  rsl_regbank #(
    .W(64),
    .DEPTH(8),
    .AW(3)
  ) u_pkd (
    .clk(pclk),
    .rst_n(presetn),
    .clr(hw_act),
    .we(bwr && bsel_r[`RSL_BSEL_BANK] == `RSL_BANK_PKD),
    .idx(bsel_r[`RSL_BSEL_ENT]),
    .wsel(bsel_r[`RSL_BSEL_WORD]),
    .wdata(pwdata),
    .rdata(pkd_rd),
    .nonzero(pkd_nz)
  );

  rsl_regbank #(
    .W(128),
    .DEPTH(8),
    .AW(3)
  ) u_vec (
    .clk(pclk),
    .rst_n(presetn),
    .clr(hw_act),
    .we(bwr && bsel_r[`RSL_BSEL_BANK] == `RSL_BANK_VEC),
    .idx(bsel_r[`RSL_BSEL_ENT]),
    .wsel(bsel_r[`RSL_BSEL_WORD]),
    .wdata(pwdata),
    .rdata(vec_rd),
    .nonzero(vec_nz)
  );

  always @* begin
    case (bsel_r[`RSL_BSEL_BANK])
      `RSL_BANK_STK: bank_rd = stk_rd;
      `RSL_BANK_PKD: bank_rd = pkd_rd;
      `RSL_BANK_VEC: bank_rd = vec_rd;
      default: bank_rd = `RSL_ZERO32;
    endcase
  end

  // ----------------------------------------
  // buffer invalidation
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inv_translation_buffers <= 1'b1;
      inv_branch_target_buffer <= 1'b1;
    end else begin
      inv_translation_buffers <= hw_act | si_evt;
      inv_branch_target_buffer <= hw_act | si_evt;
    end
  end

  // ----------------------------------------
  // self-test sequencer
  // ----------------------------------------
  // the test checks that every bank really cleared; it cannot see stuck-at-0
  reg [2:0] st_r;
  reg [2:0] st_nxt;
  reg [15:0] cnt_r;
  reg [31:0] acc_r;

  always @* begin
    case (st_r)
      ST_ARM: st_nxt = (cnt_r[3:0] == `RSL_SYNC_LAT) ? (built_in_self_test_s ? ST_BUILT_IN_SELF_TEST : ST_IDLE) : ST_ARM;
      ST_BUILT_IN_SELF_TEST: st_nxt = (cnt_r == BUILT_IN_SELF_TEST_CYCLES) ? ST_IDLE : ST_BUILT_IN_SELF_TEST;
      ST_IDLE: st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_ARM;
      cnt_r <= 16'h0000;
      acc_r <= `RSL_ZERO32;
    end else if (hw_act) begin
      // only power-up or a hard reset arms the test; soft init never reaches here
      st_r <= ST_ARM;
      cnt_r <= 16'h0000;
      acc_r <= `RSL_ZERO32;
    end else begin
      st_r <= st_nxt;
      cnt_r <= (st_nxt == st_r) ? cnt_r + 16'h0001 : 16'h0000;
      if (st_r == ST_BUILT_IN_SELF_TEST && st_nxt == ST_IDLE) begin
        acc_r <= (stk_nz | pkd_nz | vec_nz) ? `RSL_BUILT_IN_SELF_TEST_FAIL : `RSL_ZERO32;
      end
    end
  end

  assign built_in_self_test_busy = st_r[1];

  // ----------------------------------------
  // read data
  // ----------------------------------------
  reg [31:0] rd_mux;

  always @* begin
    case (paddr)
      `RSL_A_FP_CTRL: rd_mux = {16'h0000, fp_ctrl_r};
      `RSL_A_FP_STAT: rd_mux = {16'h0000, fp_stat_r};
      `RSL_A_FP_TAG: rd_mux = {16'h0000, fp_tag_r};
      `RSL_A_FP_SEL: rd_mux = fp_sel_r;
      `RSL_A_FP_DPTR: rd_mux = fp_dptr_r;
      `RSL_A_FP_IPTR: rd_mux = fp_iptr_r;
      `RSL_A_VEC_CSR: rd_mux = vcsr_r;
      `RSL_A_FLAGS: rd_mux = flags_r;
      `RSL_A_CR0: rd_mux = cr0_r;
      `RSL_A_ACC: rd_mux = acc_r;
      `RSL_A_FEAT: rd_mux = {29'h00000000, feat_r};
      `RSL_A_TSC_LO: rd_mux = tsc_r[31:0];
      `RSL_A_TSC_HI: rd_mux = tsc_r[63:32];
      `RSL_A_PERF: rd_mux = perf_r;
      `RSL_A_EVSEL: rd_mux = evsel_r;
      `RSL_A_MSR: rd_mux = msr_r;
      `RSL_A_MCA: rd_mux = mca_r;
      `RSL_A_BSEL: rd_mux = {22'h000000, bsel_r};
      `RSL_A_BDATA: rd_mux = bank_rd;
      `RSL_A_STATE: rd_mux = {29'h00000000, st_r};
      default: rd_mux = `RSL_ZERO32;
    endcase
  end

  // captured in the setup cycle so read data comes from a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `RSL_ZERO32;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end
endmodule

// ==== rsl_loader_checker.sv ====
// Purpose: port-level checks of the reset state loader
// Assumes: bound onto rsl_loader, single pclk domain
// Notes: built_in_self_test length follows the bound BUILT_IN_SELF_TEST_CYCLES value
`timescale 1ns/1ps
`include "rsl_consts.vh"
module rsl_loader_checker #(
  parameter [15:0] BUILT_IN_SELF_TEST_CYCLES = `RSL_BUILT_IN_SELF_TEST_CYC_DEF
) (
  input wire pclk,
  input wire presetn,
  input wire [`RSL_ADDR_W-1:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire hw_reset_pin,
  input wire soft_init_pin,
  input wire [31:0] control_register_zero,
  input wire local_interrupt_controller_enable,
  input wire mtrr_fixed_enable,
  input wire mtrr_var_enable,
  input wire inv_translation_buffers,
  input wire inv_branch_target_buffer,
  input wire built_in_self_test_busy
);
  logic [15:0] built_in_self_test_cnt_r;
  wire unmapped = (paddr > 8'h4c) || (paddr[1:0] != 2'h0);
  wire rd_setup = psel && !penable && !pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  // counts busy cycles so a long self-test needs no long repetition
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      built_in_self_test_cnt_r <= 16'h0000;
    end else begin
      built_in_self_test_cnt_r <= built_in_self_test_busy ? built_in_self_test_cnt_r + 16'h0001 : 16'h0000;
    end
  end
  sequence hw_held;
    hw_reset_pin [*4];
  endsequence
  sequence hw_quiet;
    !hw_reset_pin [*5];
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_ready_high: assert property (pready)
    else $error("pready dropped");
  chk_err_access: assert property (pslverr == (psel && penable && unmapped))
    else $error("pslverr does not follow an unmapped access");
  chk_rdata_hold: assert property (!$past(rd_setup) |-> $stable(prdata))
    else $error("prdata changed outside a read setup");
  chk_hw_cr0: assert property (hw_held |-> (control_register_zero & 32'h9fffffff) == 32'h00000010)
    else $error("cr0 image wrong under hard reset");
  chk_hw_feat: assert property (hw_held |-> local_interrupt_controller_enable && !mtrr_fixed_enable && !mtrr_var_enable)
    else $error("feature enables wrong under hard reset");
  chk_hw_inv: assert property (hw_held |-> inv_translation_buffers && inv_branch_target_buffer)
    else $error("buffers not invalidated under hard reset");
  chk_inv_pair: assert property (inv_translation_buffers == inv_branch_target_buffer)
    else $error("invalidate outputs disagree");
  chk_inv_pulse: assert property (hw_quiet ##0 inv_translation_buffers |=> !inv_translation_buffers)
    else $error("soft init invalidate longer than one cycle");
  chk_soft_inv: assert property (($rose(soft_init_pin) && !hw_reset_pin) |-> ##[1:6] inv_translation_buffers)
    else $error("soft init did not invalidate buffers");
  chk_built_in_self_test_len: assert property ($fell(built_in_self_test_busy) |-> built_in_self_test_cnt_r == BUILT_IN_SELF_TEST_CYCLES + 16'h0001)
    else $error("self-test length wrong");
endmodule

// ==== rsl_loader_bench.sv ====
// Purpose: self-checking bench of the reset state loader
// Assumes: apb master with one idle cycle between transfers
// Notes: row phases 0 power-up, 1 fp init, 2 soft init, 3 hard reset
`timescale 1ns/1ps
`include "rsl_consts.vh"
module rsl_loader_bench;
  localparam [15:0] BUILT_IN_SELF_TEST_N = 16'h0004;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic hw_reset_pin = 1'b0;
  logic soft_init_pin = 1'b0;
  logic built_in_self_test_req_pin = 1'b0;
  logic fp_initialize_instruction = 1'b0;
  logic perf_event = 1'b0;
  wire [31:0] prdata;
  wire [31:0] control_register_zero;
  wire pready, pslverr, local_interrupt_controller_enable, mtrr_fixed_enable, mtrr_var_enable;
  wire inv_translation_buffers, inv_branch_target_buffer, built_in_self_test_busy;
  logic [31:0] rd_v;
  logic err_v;
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int busy_cyc = 0;
  int inv_cyc = 0;
  int b0;
  int i0;
  // phase, write flag, byte address, data or expected read value
  logic [47:0] tab [$] = '{
    48'h0_0_00_00000040, 48'h0_0_04_00000000, 48'h0_0_08_00005555, 48'h0_0_0c_00000000,
    48'h0_0_10_00000000, 48'h0_0_14_00000000, 48'h0_0_18_00001f80, 48'h0_0_1c_00000002,
    48'h0_0_20_60000010, 48'h0_0_24_00000000, 48'h0_0_28_00000001, 48'h0_0_34_00000000,
    48'h0_0_38_00000000, 48'h0_1_50_12345678, 48'h0_0_50_00000000, 48'h0_1_24_ffffffff,
    48'h0_0_24_00000000, 48'h0_1_44_00000000, 48'h0_0_48_00000000, 48'h0_1_44_00000131,
    48'h0_0_48_00000000, 48'h0_1_44_00000372, 48'h0_0_48_00000000, 48'h0_1_44_00000000,
    48'h0_1_48_cafe0001, 48'h0_1_00_00001234, 48'h0_1_04_000000ab, 48'h0_1_08_00000000,
    48'h0_1_0c_11112222, 48'h0_1_10_00000033, 48'h0_1_14_00000044,
    48'h1_0_00_0000037f, 48'h1_0_04_00000000, 48'h1_0_08_0000ffff, 48'h1_0_0c_00000000,
    48'h1_0_10_00000000, 48'h1_0_14_00000000, 48'h1_0_48_cafe0001, 48'h1_1_44_00000131,
    48'h1_1_48_5a5a5a5a, 48'h1_1_18_00001f81, 48'h1_1_38_00000001, 48'h1_1_28_00000006,
    48'h1_1_3c_deadbeef, 48'h1_1_20_20000005, 48'h1_1_1c_ffffffff,
    48'h2_0_00_0000037f, 48'h2_0_08_0000ffff, 48'h2_0_48_5a5a5a5a, 48'h2_0_18_00001f81,
    48'h2_0_38_00000001, 48'h2_0_34_00000005, 48'h2_0_28_00000006, 48'h2_0_3c_deadbeef,
    48'h2_0_20_20000010, 48'h2_0_1c_ffc00002, 48'h2_1_44_00000000, 48'h2_0_48_cafe0001,
    48'h3_0_00_00000040, 48'h3_0_08_00005555, 48'h3_0_04_00000000, 48'h3_0_18_00001f80,
    48'h3_0_38_00000000, 48'h3_0_34_00000000, 48'h3_0_28_00000001, 48'h3_0_20_20000010,
    48'h3_0_1c_ffc00002, 48'h3_0_24_00000000, 48'h3_1_44_00000000, 48'h3_0_48_00000000,
    48'h3_1_44_00000131, 48'h3_0_48_00000000};
  rsl_loader #(.BUILT_IN_SELF_TEST_CYCLES(BUILT_IN_SELF_TEST_N)) uut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hw_reset_pin(hw_reset_pin), .soft_init_pin(soft_init_pin), .built_in_self_test_req_pin(built_in_self_test_req_pin),
    .fp_initialize_instruction(fp_initialize_instruction), .perf_event(perf_event),
    .control_register_zero(control_register_zero), .local_interrupt_controller_enable(local_interrupt_controller_enable),
    .mtrr_fixed_enable(mtrr_fixed_enable), .mtrr_var_enable(mtrr_var_enable),
    .inv_translation_buffers(inv_translation_buffers),
    .inv_branch_target_buffer(inv_branch_target_buffer), .built_in_self_test_busy(built_in_self_test_busy));
  always #25 pclk = ~pclk;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task tally_and_finish;
    begin
      if (errors == 0 && num_checks > 0) begin
        $display("RESULT: PASS");
      end else begin
        $display("RESULT: FAIL");
      end
      $finish;
    end
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    begin
      num_checks++;
      if (got !== exp) begin
        errors++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // idle cycle after release keeps psel from being assigned twice in one step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 100) begin
        n++;
        @(posedge pclk);
      end
      rd_v = prdata;
      err_v = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task run_phase(input logic [3:0] p);
    int i;
    begin
      for (i = 0; i < tab.size(); i++) begin
        if (tab[i][47:44] == p) begin
          apb(tab[i][40], tab[i][39:32], tab[i][31:0]);
          if (!tab[i][40]) cmp(rd_v, tab[i][31:0]);
          cmp({31'h0, err_v}, {31'h0, tab[i][39:32] == 8'h50});
        end
      end
    end
  endtask
  task wait_busy(input logic lvl);
    int n;
    begin
      n = 0;
      while (built_in_self_test_busy !== lvl && n < 100) begin
        n++;
        @(posedge pclk);
      end
      cmp({31'h0, built_in_self_test_busy}, {31'h0, lvl});
    end
  endtask
  // ----------------------------------------
  // monitors and timeout
  // ----------------------------------------
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (built_in_self_test_busy === 1'b1) busy_cyc <= busy_cyc + 1;
    if (inv_translation_buffers === 1'b1) inv_cyc <= inv_cyc + 1;
    if (cyc == 5000) begin
      errors = errors + 1;
      tally_and_finish;
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    cmp(control_register_zero, `RSL_CR0_PWRUP);
    cmp({29'h0, mtrr_var_enable, mtrr_fixed_enable, local_interrupt_controller_enable}, 32'h00000001);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    run_phase(4'h0);
    fp_initialize_instruction <= 1'b1;
    @(posedge pclk);
    fp_initialize_instruction <= 1'b0;
    @(posedge pclk);
    run_phase(4'h1);
    perf_event <= 1'b1;
    repeat (5) @(posedge pclk);
    perf_event <= 1'b0;
    built_in_self_test_req_pin <= 1'b1;
    b0 = busy_cyc;
    i0 = inv_cyc;
    soft_init_pin <= 1'b1;
    repeat (10) @(posedge pclk);
    cmp(inv_cyc - i0, 32'h00000001);
    cmp(busy_cyc - b0, 32'h00000000);
    cmp({29'h0, mtrr_var_enable, mtrr_fixed_enable, local_interrupt_controller_enable}, 32'h00000006);
    cmp(control_register_zero, 32'h20000010);
    run_phase(4'h2);
    // fp initialize during hard reset must lose to it
    hw_reset_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    fp_initialize_instruction <= 1'b1;
    @(posedge pclk);
    fp_initialize_instruction <= 1'b0;
    repeat (3) @(posedge pclk);
    b0 = busy_cyc;
    hw_reset_pin <= 1'b0;
    soft_init_pin <= 1'b0;
    wait_busy(1'b1);
    wait_busy(1'b0);
    @(posedge pclk);
    cmp(busy_cyc - b0, BUILT_IN_SELF_TEST_N + 32'h00000001);
    run_phase(4'h3);
    tally_and_finish;
  end
endmodule
bind rsl_loader rsl_loader_checker #(.BUILT_IN_SELF_TEST_CYCLES(BUILT_IN_SELF_TEST_CYCLES)) chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .hw_reset_pin(hw_reset_pin), .soft_init_pin(soft_init_pin),
  .control_register_zero(control_register_zero), .local_interrupt_controller_enable(local_interrupt_controller_enable),
  .mtrr_fixed_enable(mtrr_fixed_enable), .mtrr_var_enable(mtrr_var_enable),
  .inv_translation_buffers(inv_translation_buffers),
  .inv_branch_target_buffer(inv_branch_target_buffer), .built_in_self_test_busy(built_in_self_test_busy));
